// ---- logic/oc_detector.sv ----
`timescale 1ns/100ps
module oc_detector (
    input  wire logic aclk,
    input  wire logic aresetn,
    oc_if.det         oc
);
    stepper_pkg::oc_state_t state_r;
    logic [2:0]             cnt_r;

    // trip must persist across four oscillator ticks before it latches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= stepper_pkg::OC_IDLE;
            cnt_r   <= 3'h0;
        end else begin
            case (state_r)
                stepper_pkg::OC_IDLE: begin
                    cnt_r <= 3'h0;
                    if (oc.trip && !oc.clear) begin
                        state_r <= stepper_pkg::OC_MASK;
                    end
                end
                stepper_pkg::OC_MASK: begin
                    if (oc.trip && oc.tick && cnt_r == stepper_pkg::OC_MASK_TICKS - 3'h1) begin
                        state_r <= stepper_pkg::OC_TRIP;
                    end else if (!oc.trip || oc.clear) begin
                        state_r <= stepper_pkg::OC_IDLE; // noise pulse dropped
                    end else if (oc.tick) begin
                        cnt_r <= cnt_r + 3'h1;
                    end
                end
                stepper_pkg::OC_TRIP: begin
                    if (oc.clear) begin
                        state_r <= stepper_pkg::OC_IDLE;
                    end
                end
                default: state_r <= stepper_pkg::OC_IDLE;
            endcase
        end
    end

    // latched fault flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc.fault <= 1'b0;
        end else begin
            oc.fault <= (state_r == stepper_pkg::OC_TRIP && !oc.clear) ||
                        (state_r == stepper_pkg::OC_MASK && oc.trip && oc.tick &&
                         cnt_r == stepper_pkg::OC_MASK_TICKS - 3'h1); // set beats clear
        end
    end

    AST_OC_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        oc.fault && !oc.clear |=> oc.fault) else $error("overcurrent latch dropped");
    AST_OC_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        oc.clear && !oc.tick ##1 oc.clear |-> !oc.fault) else $error("overcurrent latch not cleared");
    AST_OC_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        state_r == stepper_pkg::OC_IDLE |=> !oc.fault) else $error("trip latched without mask");
endmodule

// ---- logic/oc_if.sv ----
`timescale 1ns/100ps
interface oc_if;
    logic tick;
    logic trip;
    logic clear;
    logic fault;
    modport det (input tick, input trip, input clear, output fault);
    modport ctl (output tick, output trip, output clear, input fault);
endinterface

// ---- logic/stepper_drive_ctrl.sv ----
`timescale 1ns/100ps
module stepper_drive_ctrl (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite slave
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // controller pins
    input  wire logic        chan_a_level_sel0,
    input  wire logic        chan_a_level_sel1,
    input  wire logic        chan_b_level_sel0,
    input  wire logic        chan_b_level_sel1,
    input  wire logic        chan_a_dir,
    input  wire logic        chan_b_dir,
    input  wire logic        standby_n,
    // analog monitors
    input  wire logic        thermal_shutdown_trip,
    input  wire logic [1:0]  overcurrent_shutdown_trip,
    input  wire logic        motor_supply_ok,
    input  wire logic        logic_supply_ok,
    // bridge and regulation outputs, index 0 is channel A
    output logic [1:0]       bridge_pos_drive,
    output logic [1:0]       bridge_neg_drive,
    output logic [1:0]       bridge_hiz,
    output logic [1:0]       current_negative,
    output logic [1:0]       chan_a_target,
    output logic [1:0]       chan_b_target,
    output logic             chop_oscillator,
    output logic             thermal_shutdown,
    output logic [1:0]       overcurrent_shutdown
);
    logic [stepper_pkg::NSYNC-1:0] meta_r;
    logic [stepper_pkg::NSYNC-1:0] sync_r;
    logic [1:0]  sel0_s, sel1_s, dir_s, oc_trip_s;
    logic        stby_s, therm_s, supply_s;
    logic [4:0]  div_r;
    logic        drv_en_r;
    logic [1:0]  oc_fault;
    logic [1:0]  active;
    logic        aw_got_r, w_got_r;
    logic [3:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;

    function automatic logic addr_known(input logic [3:0] a);
        addr_known = (a == stepper_pkg::ADDR_CTRL) || (a == stepper_pkg::ADDR_STATUS);
    endfunction

    // every pin passes two flops; the first stage is read by nothing else
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= {chan_b_level_sel1, chan_b_level_sel0, chan_a_level_sel1,
                       chan_a_level_sel0, chan_b_dir, chan_a_dir, standby_n,
                       thermal_shutdown_trip, overcurrent_shutdown_trip,
                       motor_supply_ok, logic_supply_ok};
            sync_r <= meta_r;
        end
    end

    assign sel1_s    = {sync_r[11], sync_r[9]};
    assign sel0_s    = {sync_r[10], sync_r[8]};
    assign dir_s     = sync_r[7:6];
    assign stby_s    = sync_r[5];
    assign therm_s   = sync_r[4];
    assign oc_trip_s = sync_r[3:2];
    assign supply_s  = sync_r[1] & sync_r[0];

    // chop oscillator: a one-cycle enable, stopped with its divider cleared in standby or undervoltage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r           <= 5'h0;
            chop_oscillator <= 1'b0;
        end else if (!stby_s || !supply_s) begin
            div_r           <= 5'h0;
            chop_oscillator <= 1'b0;
        end else begin
            div_r           <= (div_r == stepper_pkg::CHOP_LAST) ? 5'h0 : div_r + 5'h1;
            chop_oscillator <= (div_r == stepper_pkg::CHOP_LAST);
        end
    end

    // thermal latch; a trip in the clearing cycle still wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            thermal_shutdown <= 1'b0;
        end else if (therm_s) begin
            thermal_shutdown <= 1'b1;
        end else if (!stby_s) begin
            thermal_shutdown <= 1'b0;
        end
    end

    // per-channel overcurrent detectors; standby low acts as the clear
    for (genvar i = 0; i < 2; i++) begin : g_oc
        oc_if ocb ();
        assign ocb.tick   = chop_oscillator;
        assign ocb.trip   = oc_trip_s[i];
        assign ocb.clear  = !stby_s;
        assign oc_fault[i] = ocb.fault;
        oc_detector u_det (
            .aclk    (aclk),
            .aresetn (aresetn),
            .oc      (ocb)
        );
    end

    // a channel drives only if every enable and every protection agrees
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            active[i] = (sel0_s[i] | sel1_s[i]) & stby_s & supply_s & drv_en_r &
                        !thermal_shutdown & !therm_s & !oc_fault[i];
        end
    end

    // bridge outputs, registered so the pins never glitch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bridge_pos_drive     <= 2'h0;
            bridge_neg_drive     <= 2'h0;
            bridge_hiz           <= 2'h3;
            current_negative     <= 2'h0;
            chan_a_target        <= 2'h0;
            chan_b_target        <= 2'h0;
            overcurrent_shutdown <= 2'h0;
        end else begin
            bridge_hiz           <= ~active;
            bridge_pos_drive     <= active & dir_s;
            bridge_neg_drive     <= active & ~dir_s;
            current_negative     <= active & ~dir_s;
            chan_a_target        <= active[0] ? {sel0_s[0], sel1_s[0]} : 2'h0;
            chan_b_target        <= active[1] ? {sel0_s[1], sel1_s[1]} : 2'h0;
            overcurrent_shutdown <= oc_fault;
        end
    end

    // write channel: address and data taken in either order, then one response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= stepper_pkg::RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= 4'h0;
            wdata_r       <= 32'h0;
            wstrb_r       <= 4'h0;
            drv_en_r      <= stepper_pkg::CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (aw_got_r && w_got_r && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(awaddr_r) ? stepper_pkg::RESP_OKAY
                                                     : stepper_pkg::RESP_DECERR;
                if (awaddr_r == stepper_pkg::ADDR_CTRL && wstrb_r[0]) begin
                    drv_en_r <= wdata_r[stepper_pkg::CTRL_DRV_EN];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_got_r      <= 1'b0;
                w_got_r       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: data registered on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= stepper_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_known(s_axi_araddr) ? stepper_pkg::RESP_OKAY
                                                      : stepper_pkg::RESP_DECERR;
            s_axi_rdata   <= 32'h0;
            if (s_axi_araddr == stepper_pkg::ADDR_CTRL) begin
                s_axi_rdata[stepper_pkg::CTRL_DRV_EN] <= drv_en_r;
            end else if (s_axi_araddr == stepper_pkg::ADDR_STATUS) begin
                s_axi_rdata[stepper_pkg::ST_THERM]   <= thermal_shutdown;
                s_axi_rdata[stepper_pkg::ST_OC_A]    <= oc_fault[0];
                s_axi_rdata[stepper_pkg::ST_OC_B]    <= oc_fault[1];
                s_axi_rdata[stepper_pkg::ST_STBY_N]  <= stby_s;
                s_axi_rdata[stepper_pkg::ST_SUPPLY]  <= supply_s;
                s_axi_rdata[stepper_pkg::ST_TGT_A+:2] <= chan_a_target;
                s_axi_rdata[stepper_pkg::ST_TGT_B+:2] <= chan_b_target;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_stby_cycle;
        stby_s ##1 (!stby_s && !therm_s) ##1 stby_s;
    endsequence

    AST_HIZ_OFF: assert property (sel0_s[0] == 1'b0 && sel1_s[0] == 1'b0 |=> bridge_hiz[0])
        else $error("channel A not high impedance with selects low");
    AST_DIR_POS: assert property (active[1] && dir_s[1] |=>
        bridge_pos_drive[1] && !bridge_neg_drive[1] && !current_negative[1])
        else $error("channel B direction mismatch");
    AST_STBY_OFF: assert property (!stby_s |=> bridge_hiz == 2'h3 && !chop_oscillator)
        else $error("standby did not stop drivers and oscillator");
    AST_TSD_OFF: assert property (therm_s |=> thermal_shutdown && bridge_hiz == 2'h3)
        else $error("thermal trip did not shut outputs");
    AST_TSD_CLEAR: assert property (thermal_shutdown ##0 s_stby_cycle
        |-> !thermal_shutdown) else $error("thermal latch not cleared by standby");
    AST_SUPPLY_OFF: assert property (!supply_s |=> bridge_hiz == 2'h3)
        else $error("outputs active during undervoltage");
    AST_OC_OFF: assert property (oc_fault[0] |=> bridge_hiz[0] && overcurrent_shutdown[0])
        else $error("overcurrent did not turn channel A off");
    AST_TARGET: assert property (active[0] |=> chan_a_target == $past({sel0_s[0], sel1_s[0]}))
        else $error("channel A current target wrong");
endmodule

// ---- logic/stepper_pkg.sv ----
package stepper_pkg;
    // clocking and the chop oscillator divider
    localparam int        CLK_FREQ_KHZ  = 50000;
    localparam int        CHOP_FREQ_KHZ = 1600;
    localparam int        CHOP_DIV      = CLK_FREQ_KHZ / CHOP_FREQ_KHZ;
    localparam logic [4:0] CHOP_LAST    = 5'(CHOP_DIV - 1);
    localparam logic [2:0] OC_MASK_TICKS = 3'h4;

    // register map, byte addresses
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam int         CTRL_DRV_EN = 0;
    localparam logic       CTRL_RESET  = 1'b1;
    localparam int         ST_THERM    = 0;
    localparam int         ST_OC_A     = 1;
    localparam int         ST_OC_B     = 2;
    localparam int         ST_STBY_N   = 3;
    localparam int         ST_SUPPLY   = 4;
    localparam int         ST_TGT_A    = 5;
    localparam int         ST_TGT_B    = 7;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // input bundle width, in bits, through the two-flop synchroniser
    localparam int NSYNC = 12;

    typedef enum logic [2:0] {
        OC_IDLE = 3'b001,
        OC_MASK = 3'b010,
        OC_TRIP = 3'b100
    } oc_state_t;
endpackage

// ---- verif/motion_ctrl_model.sv ----
`timescale 1ns/100ps
// controller side: turns bench requests into pin levels with the host's own pacing
module motion_ctrl_model #(
    parameter int MIN_GAP = 63
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] req_lvl,
    input  wire logic [1:0] req_dir,
    input  wire logic       req_stby,
    output logic            chan_a_level_sel0,
    output logic            chan_a_level_sel1,
    output logic            chan_b_level_sel0,
    output logic            chan_b_level_sel1,
    output logic            chan_a_dir,
    output logic            chan_b_dir,
    output logic            standby_n
);
    logic [7:0] gap_r;

    // selects held low while power comes up so no bridge fires before the device is ready
    always_ff @(posedge aclk) begin
        {chan_b_level_sel1, chan_b_level_sel0, chan_a_level_sel1, chan_a_level_sel0}
            <= aresetn ? req_lvl : 4'h0;
        standby_n <= aresetn ? req_stby : 1'b1;
    end

    // direction edges kept at least half a 400 kHz period apart; late requests wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {chan_b_dir, chan_a_dir} <= 2'h3;
            gap_r <= 8'h00;
        end else if ({chan_b_dir, chan_a_dir} != req_dir && gap_r >= 8'(MIN_GAP)) begin
            {chan_b_dir, chan_a_dir} <= req_dir;
            gap_r <= 8'h00;
        end else if (gap_r != 8'hFF) begin
            gap_r <= gap_r + 8'h01;
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); miscompares++; end end
module tb;
    logic        aclk, aresetn;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, req_lvl;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, req_dir;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, req_stby;
    logic        chan_a_level_sel0, chan_a_level_sel1, chan_b_level_sel0, chan_b_level_sel1;
    logic        chan_a_dir, chan_b_dir, standby_n, thermal_shutdown_trip;
    logic        motor_supply_ok, logic_supply_ok, chop_oscillator, thermal_shutdown;
    logic [1:0]  overcurrent_shutdown_trip, bridge_pos_drive, bridge_neg_drive, bridge_hiz;
    logic [1:0]  current_negative, chan_a_target, chan_b_target, overcurrent_shutdown;
    int          miscompares, check_count;

    stepper_drive_ctrl stepper_drive_ctrl_inst (.*);
    motion_ctrl_model motion_ctrl_model_inst (.*);

    // 50 MHz
    always #10 aclk = ~aclk;

    task stop_test();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task tmo(input int n);
        if (n >= 200) begin
            $display("MISMATCH handshake exp done got timeout");
            miscompares++;
            stop_test();
        end
    endtask

    // both channels' pins in one go; expectations come from the caller
    task pins(input logic [1:0] hz, pos, neg, ta, tb_t);
        `CHK("hiz", hz, bridge_hiz)
        `CHK("pos", pos, bridge_pos_drive)
        `CHK("neg", neg, bridge_neg_drive)
        `CHK("curneg", neg, current_negative)
        `CHK("tgt_a", ta, chan_a_target)
        `CHK("tgt_b", tb_t, chan_b_target)
    endtask

    task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int  n;
        logic aw, w;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        aw = 1'b0;
        w = 1'b0;
        n = 0;
        while (!(aw && w) && n < 200) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            n++;
        end
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        tmo(n);
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'b1 && n < 200);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        tmo(n);
        s_axi_rready <= 1'b0;
        `CHK("rdata", ed, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask

    // the model may hold a direction change back, so allow its full gap
    task apply(input logic [3:0] l, input logic [1:0] d);
        @(posedge aclk);
        req_lvl <= l;
        req_dir <= d;
        repeat (70) @(posedge aclk);
    endtask

    task ticks(input int cyc, input int ex);
        int k;
        k = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (chop_oscillator === 1'b1)
                k++;
        end
        `CHK("chop_ticks", ex, k)
    endtask

    task stby_cycle();
        @(posedge aclk);
        req_stby <= 1'b0;
        repeat (8) @(posedge aclk);
        req_stby <= 1'b1;
        repeat (8) @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        req_lvl = 4'h0;
        req_dir = 2'h3;
        req_stby = 1'b1;
        {thermal_shutdown_trip, overcurrent_shutdown_trip} = 3'h0;
        {motor_supply_ok, logic_supply_ok} = 2'h3;
        miscompares = 0;
        check_count = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        apply(4'h0, 2'h3);
        pins(2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
        // every level code with both directions: target = {sel0, sel1}
        for (int c = 0; c < 4; c++) begin
            for (int d = 0; d < 2; d++) begin
                apply({c[0], c[1], c[0], c[1]}, {d[0], d[0]});
                pins((c == 0) ? 2'h3 : 2'h0, (c != 0 && d == 1) ? 2'h3 : 2'h0,
                     (c != 0 && d == 0) ? 2'h3 : 2'h0, 2'(c), 2'(c));
            end
        end
        apply(4'hB, 2'h3);
        axi_rd(stepper_pkg::ADDR_STATUS, 32'h000000F8, stepper_pkg::RESP_OKAY);
        axi_rd(4'h8, 32'h00000000, stepper_pkg::RESP_DECERR);
        axi_wr(4'hC, 32'h00000000, stepper_pkg::RESP_DECERR);
        axi_wr(stepper_pkg::ADDR_STATUS, 32'h00000000, stepper_pkg::RESP_OKAY);
        axi_wr(stepper_pkg::ADDR_CTRL, 32'h00000000, stepper_pkg::RESP_OKAY);
        repeat (6) @(posedge aclk);
        pins(2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
        axi_wr(stepper_pkg::ADDR_CTRL, 32'h00000001, stepper_pkg::RESP_OKAY);
        // a write with byte lane 0 off must leave the enable alone
        s_axi_wstrb <= 4'hE;
        axi_wr(stepper_pkg::ADDR_CTRL, 32'h00000000, stepper_pkg::RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_rd(stepper_pkg::ADDR_CTRL, 32'h00000001, stepper_pkg::RESP_OKAY);
        apply(4'hF, 2'h3);
        ticks(93, 3);
        req_stby <= 1'b0;
        repeat (6) @(posedge aclk);
        pins(2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
        ticks(93, 0);
        req_stby <= 1'b1;
        // each supply monitor alone must hold the bridges off
        for (int i = 0; i < 2; i++) begin
            {motor_supply_ok, logic_supply_ok} <= (i == 0) ? 2'h1 : 2'h2;
            repeat (6) @(posedge aclk);
            pins(2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
            {motor_supply_ok, logic_supply_ok} <= 2'h3;
            repeat (6) @(posedge aclk);
            pins(2'h0, 2'h3, 2'h0, 2'h3, 2'h3);
        end
        thermal_shutdown_trip <= 1'b1;
        repeat (3) @(posedge aclk);
        thermal_shutdown_trip <= 1'b0;
        repeat (20) @(posedge aclk);
        `CHK("thermal_shutdown", 1'b1, thermal_shutdown)
        pins(2'h3, 2'h0, 2'h0, 2'h0, 2'h0);
        axi_rd(stepper_pkg::ADDR_STATUS, 32'h00000019, stepper_pkg::RESP_OKAY);
        stby_cycle();
        `CHK("thermal_shutdown", 1'b0, thermal_shutdown)
        pins(2'h0, 2'h3, 2'h0, 2'h3, 2'h3);
        // short trip is masked, a long one latches only its own channel
        for (int m = 1; m < 3; m++) begin
            overcurrent_shutdown_trip <= 2'(m);
            repeat (60) @(posedge aclk);
            overcurrent_shutdown_trip <= 2'h0;
            repeat (6) @(posedge aclk);
            `CHK("oc_short", 2'h0, overcurrent_shutdown)
            overcurrent_shutdown_trip <= 2'(m);
            repeat (200) @(posedge aclk);
            overcurrent_shutdown_trip <= 2'h0;
            repeat (20) @(posedge aclk);
            `CHK("oc_latch", 2'(m), overcurrent_shutdown)
            pins(2'(m), ~2'(m), 2'h0, (m == 1) ? 2'h0 : 2'h3, (m == 2) ? 2'h0 : 2'h3);
            axi_rd(stepper_pkg::ADDR_STATUS, (m == 1) ? 32'h0000019A : 32'h0000007C,
                   stepper_pkg::RESP_OKAY);
            stby_cycle();
            `CHK("oc_clear", 2'h0, overcurrent_shutdown)
            pins(2'h0, 2'h3, 2'h0, 2'h3, 2'h3);
        end
        // power-on reset alone must clear both kinds of latch
        thermal_shutdown_trip <= 1'b1;
        overcurrent_shutdown_trip <= 2'h3;
        repeat (200) @(posedge aclk);
        {thermal_shutdown_trip, overcurrent_shutdown_trip} <= 3'h0;
        repeat (6) @(posedge aclk);
        `CHK("latched", 3'h7, {thermal_shutdown, overcurrent_shutdown})
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("por_clear", 3'h0, {thermal_shutdown, overcurrent_shutdown})
        `CHK("por_hiz", 2'h3, bridge_hiz)
        repeat (8) @(posedge aclk);
        pins(2'h0, 2'h3, 2'h0, 2'h3, 2'h3);
        stop_test();
    end
endmodule
